//--- rtl/operand_field_decoder.sv
// Operand field decoder: gathers object code bytes and splits operand fields.
`timescale 1ns/1ps
`include "operand_decoder_params.svh"
module operand_field_decoder (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_code_valid,
  input  wire logic [7:0]                    i_code_byte,
  input  wire operand_decoder_pkg::format_t  i_format,
  input  wire logic [15:0]                   i_instr_addr,
  input  wire logic [7:0]                    i_working_bank_pointer,
  input  wire logic [3:0]                    i_flags,
  output logic                               o_ready,
  output logic                               o_done,
  output logic [7:0]                         o_opcode,
  output logic [11:0]                        o_src_addr,
  output logic [11:0]                        o_dst_addr,
  output logic [7:0]                         o_immediate_operand,
  output logic [15:0]                        o_direct_address_operand,
  output logic [15:0]                        o_target_addr,
  output logic [11:0]                        o_index_addr,
  output logic [2:0]                         o_bit_idx,
  output logic                               o_polarity,
  output logic [7:0]                         o_vector,
  output logic [3:0]                         o_branch_condition_field,
  output logic                               o_branch_taken,
  output logic                               o_operand_err
);
  import operand_decoder_pkg::*;

  dec_state_t  state_q, state_d;
  format_t     fmt_q, fmt_in;
  logic [7:0]  bytes_q [0:2];
  logic [1:0]  cnt_q;
  logic [2:0]  len_q, len_in;
  logic [15:0] addr_q;
  logic [7:0]  rp_q;
  logic        taken_w;
  logic [15:0] idx_off_w;

  // Instruction length in bytes, opcode included.
  function automatic logic [2:0] fmt_len(input format_t f);
    unique case (f)
      FMT_NONE:                                fmt_len = `LEN_ONE;
      FMT_JRCC, FMT_RR, FMT_WPAIR, FMT_BIT,
      FMT_VEC:                                 fmt_len = `LEN_TWO;
      FMT_R_R, FMT_R_IM, FMT_DA, FMT_JPCC,
      FMT_X:                                   fmt_len = `LEN_THREE;
      FMT_ER_ER, FMT_ER_IM:                    fmt_len = `LEN_FOUR;
      default:                                 fmt_len = `LEN_ONE;
    endcase
  endfunction : fmt_len

  // Eight-bit register field to a 12-bit location; an escaped byte picks a
  // working register inside the bank that the pointer selects.
  function automatic logic [11:0] reg8_map(input logic [7:0] b,
                                           input logic [7:0] rp);
    if (b[7:4] == `ESC_NIBBLE) begin
      reg8_map = {rp[3:0], rp[7:4], b[3:0]};
    end else begin
      reg8_map = {4'h0, b};
    end
  endfunction : reg8_map

  // Working register number to its 12-bit location.
  function automatic logic [11:0] work_map(input logic [3:0] n,
                                           input logic [7:0] rp);
    work_map = {rp[3:0], rp[7:4], n};
  endfunction : work_map

  // Signed byte widened so that negative offsets wrap.
  function automatic logic [15:0] sext8(input logic [7:0] d);
    sext8 = {{8{d[7]}}, d};
  endfunction : sext8

  // The add-register opcode has a fixed layout, whatever the caller says.
  assign fmt_in = (i_code_byte == `OPC_ADD_REG) ? FMT_R_R : i_format;
  assign len_in = fmt_len(fmt_in);

  // The index byte is widened once here, as a call result cannot be part-selected.
  assign idx_off_w = sext8(bytes_q[1]);

  // Flag test runs on the live flags at decode time.
  branch_condition_eval branch_condition_eval_inst (
    .i_branch_condition_field (o_opcode[`CC_MSB:`CC_LSB]),
    .i_flags                  (i_flags),
    .o_taken                  (taken_w)
  );

  // Sequencer: take opcode, gather operand bytes, then one decode cycle.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (i_code_valid) begin
          state_d = (len_in == `LEN_ONE) ? ST_DECODE : ST_COLLECT;
        end
      end
      ST_COLLECT: begin
        if (i_code_valid && ({1'b0, cnt_q} == len_q - `LEN_TWO)) begin
          state_d = ST_DECODE;
        end
      end
      ST_DECODE: state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      o_ready <= 1'b0;
    end else begin
      state_q <= state_d;
      o_ready <= (state_d != ST_DECODE);
    end
  end

  // Opcode capture with its format, length, address and bank pointer.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_opcode <= 8'h00;
      fmt_q    <= FMT_NONE;
      len_q    <= `LEN_ONE;
      addr_q   <= 16'h0000;
      rp_q     <= 8'h00;
    end else if (state_q == ST_IDLE && i_code_valid) begin
      o_opcode <= i_code_byte;
      fmt_q    <= fmt_in;
      len_q    <= len_in;
      addr_q   <= i_instr_addr;
      rp_q     <= i_working_bank_pointer;
    end
  end

  // Operand bytes are stored in arrival order; meaning comes from format.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q      <= 2'h0;
      bytes_q[0] <= 8'h00;
      bytes_q[1] <= 8'h00;
      bytes_q[2] <= 8'h00;
    end else if (state_q == ST_IDLE) begin
      cnt_q <= 2'h0;
    end else if (state_q == ST_COLLECT && i_code_valid) begin
      bytes_q[cnt_q] <= i_code_byte;
      cnt_q          <= cnt_q + 2'h1;
    end
  end

  // Field split, done in the decode cycle so bytes stay stable afterwards.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done                   <= 1'b0;
      o_src_addr               <= 12'h000;
      o_dst_addr               <= 12'h000;
      o_immediate_operand      <= 8'h00;
      o_direct_address_operand <= 16'h0000;
      o_target_addr            <= 16'h0000;
      o_index_addr             <= 12'h000;
      o_bit_idx                <= 3'h0;
      o_polarity               <= 1'b0;
      o_vector                 <= 8'h00;
      o_branch_condition_field <= 4'h0;
      o_branch_taken           <= 1'b0;
      o_operand_err            <= 1'b0;
    end else begin
      o_done <= (state_q == ST_DECODE);
      if (state_q == ST_DECODE) begin
        o_operand_err            <= 1'b0;
        o_branch_taken           <= 1'b0;
        o_branch_condition_field <= o_opcode[`CC_MSB:`CC_LSB];
        unique case (fmt_q)
          FMT_R_R: begin
            o_src_addr <= reg8_map(bytes_q[0], rp_q);
            o_dst_addr <= reg8_map(bytes_q[1], rp_q);
          end
          FMT_R_IM: begin
            o_dst_addr          <= reg8_map(bytes_q[0], rp_q);
            o_immediate_operand <= bytes_q[1];
          end
          FMT_ER_ER: begin
            o_src_addr <= {bytes_q[0], bytes_q[1][7:4]};
            o_dst_addr <= {bytes_q[1][3:0], bytes_q[2]};
          end
          FMT_ER_IM: begin
            o_immediate_operand <= bytes_q[0];
            o_dst_addr          <= {bytes_q[1], bytes_q[2][7:4]};
          end
          FMT_DA: begin
            o_direct_address_operand <= {bytes_q[0], bytes_q[1]};
          end
          FMT_JPCC: begin
            o_direct_address_operand <= {bytes_q[0], bytes_q[1]};
            o_target_addr            <= {bytes_q[0], bytes_q[1]};
            o_branch_taken           <= taken_w;
          end
          FMT_JRCC: begin
            // Relative jumps count from the byte after this instruction.
            o_target_addr  <= addr_q + {13'h0000, len_q} + sext8(bytes_q[0]);
            o_branch_taken <= taken_w;
          end
          FMT_RR: begin
            o_dst_addr    <= reg8_map(bytes_q[0], rp_q);
            o_operand_err <= bytes_q[0][0];
          end
          FMT_WPAIR: begin
            o_dst_addr    <= work_map(bytes_q[0][7:4], rp_q);
            o_src_addr    <= work_map(bytes_q[0][3:0], rp_q);
            o_operand_err <= bytes_q[0][0];
          end
          FMT_X: begin
            o_dst_addr   <= work_map(bytes_q[0][7:4], rp_q);
            o_src_addr   <= work_map(bytes_q[0][3:0], rp_q);
            // Only the low 12 bits of the widened sum address the file.
            o_index_addr <= work_map(bytes_q[0][3:0], rp_q)
                            + idx_off_w[11:0];
          end
          FMT_BIT: begin
            o_polarity <= bytes_q[0][`BIT_POL_POS];
            o_bit_idx  <= bytes_q[0][`BIT_IDX_MSB:`BIT_IDX_LSB];
            o_dst_addr <= work_map(bytes_q[0][3:0], rp_q);
          end
          FMT_VEC: begin
            o_vector <= bytes_q[0];
          end
          FMT_NONE: begin
            o_operand_err <= 1'b0;
          end
          default: begin
            o_operand_err <= 1'b1;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  chk_add_order: assert property (
    o_done && o_opcode == `OPC_ADD_REG && bytes_q[0][7:4] != `ESC_NIBBLE &&
      bytes_q[1][7:4] != `ESC_NIBBLE |->
      o_src_addr == {4'h0, bytes_q[0]} && o_dst_addr == {4'h0, bytes_q[1]})
    else $error("Add operands not taken as source then destination.");
  chk_escape_map: assert property (
    o_done && fmt_q == FMT_R_R && bytes_q[0][7:4] == `ESC_NIBBLE |->
      o_src_addr == {rp_q[3:0], rp_q[7:4], bytes_q[0][3:0]})
    else $error("Escaped register byte did not select a working register.");
  chk_bit_index: assert property (
    o_done && fmt_q == FMT_BIT |-> o_bit_idx == bytes_q[0][6:4])
    else $error("Bit index field wrong.");
  chk_direct_addr: assert property (
    o_done && fmt_q == FMT_DA |-> o_direct_address_operand == {bytes_q[0], bytes_q[1]})
    else $error("Direct address not the two operand bytes.");
  chk_ext_register: assert property (
    o_done && fmt_q == FMT_ER_ER |-> o_dst_addr == {bytes_q[1][3:0], bytes_q[2]})
    else $error("Extended register destination wrong.");
  chk_immediate_byte: assert property (
    o_done && fmt_q == FMT_R_IM |-> o_immediate_operand == bytes_q[1])
    else $error("Immediate byte wrong.");
  chk_odd_pair: assert property (
    o_done && (fmt_q == FMT_RR || fmt_q == FMT_WPAIR) |-> o_operand_err == bytes_q[0][0])
    else $error("Odd register pair not flagged.");
  chk_rel_target: assert property (
    o_done && fmt_q == FMT_JRCC |->
      o_target_addr == addr_q + 16'h0002 + {{8{bytes_q[0][7]}}, bytes_q[0]})
    else $error("Relative target not next address plus signed offset.");
  chk_index_offset: assert property (
    o_done && fmt_q == FMT_X |->
      o_index_addr == o_src_addr + {{4{bytes_q[1][7]}}, bytes_q[1]})
    else $error("Indexed location wrong.");
  chk_polarity_bit: assert property (
    o_done && fmt_q == FMT_BIT |-> o_polarity == bytes_q[0][7])
    else $error("Polarity bit wrong.");
  chk_vector_byte: assert property (
    o_done && fmt_q == FMT_VEC |-> o_vector == bytes_q[0])
    else $error("Vector number wrong.");
  chk_cc_fixed: assert property (
    o_done && (fmt_q == FMT_JRCC || fmt_q == FMT_JPCC) |->
      (o_branch_condition_field != `CC_ALWAYS_TRUE || o_branch_taken) &&
      (o_branch_condition_field != `CC_ALWAYS_FALSE || !o_branch_taken))
    else $error("Always-true or always-false condition misjudged.");
  chk_backward_wrap: assert property (
    o_done && fmt_q == FMT_JRCC && bytes_q[0] == 8'hFF |-> o_target_addr == addr_q + 16'h0001)
    else $error("Negative displacement did not wrap.");
  chk_short_latency: assert property (
    state_q == ST_IDLE && i_code_valid && len_in == `LEN_ONE |-> ##1 !o_ready ##1 o_done)
    else $error("Single-byte instruction not finished in two cycles.");
  chk_jp_target: assert property (
    o_done && fmt_q == FMT_JPCC |-> o_target_addr == {bytes_q[0], bytes_q[1]})
    else $error("Absolute jump target not the two operand bytes.");
  chk_ext_imm: assert property (
    o_done && fmt_q == FMT_ER_IM |->
      o_immediate_operand == bytes_q[0] && o_dst_addr == {bytes_q[1], bytes_q[2][7:4]})
    else $error("Extended register with immediate split wrong.");
  chk_bad_format: assert property (
    o_done && 4'(fmt_q) > 4'hC |-> o_operand_err)
    else $error("Unknown layout not flagged.");
  chk_decode_gap: assert property (
    !o_ready |=> o_ready)
    else $error("Ready held low for more than one cycle.");

  cov_add_reg: cover property (o_done && o_opcode == `OPC_ADD_REG);
  cov_rel_taken: cover property (o_done && fmt_q == FMT_JRCC && o_branch_taken);
  cov_ext_four: cover property (o_done && fmt_q == FMT_ER_ER);
  cov_odd_pair: cover property (o_done && o_operand_err);
  cov_jp_taken: cover property (o_done && fmt_q == FMT_JPCC && o_branch_taken);
endmodule : operand_field_decoder

//--- inc/operand_decoder_params.svh
// Constants of the operand field decoder.
// Summary of operation
// - Opcode 04 takes source byte, then destination.
// - Escaped byte Ex selects working register x.
// - Bit index is three bits, zero to seven.
// - Direct address spans full sixteen bits.
// - Extended register address spans twelve bits.
// - Immediate is one full eight-bit byte.
// - Register pairs are even; odd pairs flagged.
// - Relative displacement added to next instruction.
// - Index byte offsets base register, signed.
// - Polarity bit chooses clear or set.
// - Vector number is a full eight-bit byte.
// - Condition in opcode bits 7:4 tests flags.
`ifndef OPERAND_DECODER_PARAMS_SVH
`define OPERAND_DECODER_PARAMS_SVH
`define OPC_ADD_REG     8'h04
`define ESC_NIBBLE      4'hE
`define CC_MSB          7
`define CC_LSB          4
`define BIT_POL_POS     7
`define BIT_IDX_MSB     6
`define BIT_IDX_LSB     4
`define LEN_ONE         3'h1
`define LEN_TWO         3'h2
`define LEN_THREE       3'h3
`define LEN_FOUR        3'h4
`define CC_ALWAYS_FALSE 4'h0
`define CC_ALWAYS_TRUE  4'h8
`endif

//--- inc/operand_decoder_pkg.sv
// Types shared by the operand field decoder files.
package operand_decoder_pkg;
  typedef enum logic [3:0] {
    FMT_NONE  = 4'b0000, FMT_R_R   = 4'b0001, FMT_R_IM  = 4'b0010,
    FMT_ER_ER = 4'b0011, FMT_DA    = 4'b0100, FMT_JPCC  = 4'b0101,
    FMT_JRCC  = 4'b0110, FMT_RR    = 4'b0111, FMT_WPAIR = 4'b1000,
    FMT_X     = 4'b1001, FMT_BIT   = 4'b1010, FMT_VEC   = 4'b1011,
    FMT_ER_IM = 4'b1100
  } format_t;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_COLLECT = 2'b01,
    ST_DECODE  = 2'b10
  } dec_state_t;
endpackage : operand_decoder_pkg

//--- rtl/branch_condition_eval.sv
// Flag test for the branch condition field of conditional jumps.
`timescale 1ns/1ps
`include "operand_decoder_params.svh"
module branch_condition_eval (
  input  wire logic [3:0] i_branch_condition_field,
  input  wire logic [3:0] i_flags,
  output logic            o_taken
);
  logic c_f, z_f, s_f, v_f;
  logic base;
  assign {c_f, z_f, s_f, v_f} = i_flags;
  // Codes 8..F are the negation of codes 0..7, so only the low half is tabled.
  always_comb begin
    unique case (i_branch_condition_field[2:0])
      3'h0:    base = 1'b0;
      3'h1:    base = s_f ^ v_f;
      3'h2:    base = z_f | (s_f ^ v_f);
      3'h3:    base = c_f | z_f;
      3'h4:    base = v_f;
      3'h5:    base = s_f;
      3'h6:    base = z_f;
      3'h7:    base = c_f;
    endcase
    o_taken = base ^ i_branch_condition_field[3];
  end
endmodule : branch_condition_eval

//--- verification/code_memory_model.sv
// Program memory model that streams object code bytes into the decoder.
`timescale 1ns/1ps
module code_memory_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ready,
  input  wire logic        i_start,
  input  wire logic [2:0]  i_len,
  input  wire logic [31:0] i_bytes,
  output logic             o_valid,
  output logic [7:0]       o_byte,
  output logic             o_busy
);
  int   idx;
  logic took;

  // Give o_valid and o_byte a value before the first reset edge is seen.
  initial begin
    o_valid = 1'b0;
    o_byte  = 8'h00;
  end

  // A byte counts as taken only at a rising edge where ready is high.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy = 1'b0;
      took   = 1'b0;
      idx    = 0;
    end else begin
      took = o_valid && i_ready;
      if (i_start && !o_busy) begin
        o_busy = 1'b1;
        idx    = 0;
        took   = 1'b0;
      end
    end
  end

  // Bytes change at the falling edge; an idle line toggles so no stale byte looks valid.
  always @(negedge i_clk) begin
    if (o_busy) begin
      if (took) begin
        idx = idx + 1;
      end
      took = 1'b0;
      if (idx == int'(i_len)) begin
        o_busy  = 1'b0;
        o_valid = 1'b0;
        o_byte  = ~o_byte;
      end else begin
        o_valid = 1'b1;
        o_byte  = i_bytes[31-8*idx -: 8];
      end
    end else if (!o_valid) begin
      o_byte = ~o_byte;
    end
  end
endmodule : code_memory_model

//--- verification/operand_field_decoder_test.sv
// Self-checking testbench of the operand field decoder.
`timescale 1ns/1ps
module operand_field_decoder_test;
  import operand_decoder_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        start = 1'b0;
  logic [2:0]  len_in = 3'h0;
  logic [31:0] bytes_in = 32'h0000_0000;
  format_t     fmt_in = FMT_NONE;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0]  bp_in = 8'h00;
  logic [3:0]  flags = 4'b1000;
  logic        valid, ready, done, busy, pol, taken, err;
  logic [7:0]  cbyte, imm, vec, opc;
  logic [11:0] src, dst, idx_a;
  logic [15:0] dir, tgt;
  logic [2:0]  bidx;
  logic [3:0]  ccf;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  always #25 clk = ~clk;

  operand_field_decoder operand_field_decoder_inst (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_code_valid(valid), .i_code_byte(cbyte),
    .i_format(fmt_in), .i_instr_addr(addr_in), .i_working_bank_pointer(bp_in),
    .i_flags(flags), .o_ready(ready), .o_done(done), .o_opcode(opc), .o_src_addr(src),
    .o_dst_addr(dst), .o_immediate_operand(imm), .o_direct_address_operand(dir),
    .o_target_addr(tgt), .o_index_addr(idx_a), .o_bit_idx(bidx), .o_polarity(pol),
    .o_vector(vec), .o_branch_condition_field(ccf), .o_branch_taken(taken),
    .o_operand_err(err));

  code_memory_model code_memory_model_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_ready(ready), .i_start(start), .i_len(len_in),
    .i_bytes(bytes_in), .o_valid(valid), .o_byte(cbyte), .o_busy(busy));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One instruction: bytes go out through the memory model, then wait for done.
  task automatic run(input format_t f, input logic [15:0] a, input logic [7:0] bp,
                     input logic [2:0] n, input logic [31:0] b);
    int k;
    @(negedge clk);
    fmt_in = f;
    addr_in = a;
    bp_in = bp;
    len_in = n;
    bytes_in = b;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) break;
    end
    check("done", {15'h0, k < 40}, 16'h0001);
  endtask : run

  task automatic t_add();
    run(FMT_NONE, 16'h0000, 8'h21, 3'h3, 32'h0408_4300);
    check("src", {4'h0, src}, 16'h0008);
    check("dst", {4'h0, dst}, 16'h0043);
    check("opcode", {8'h0, opc}, 16'h0004);
    run(FMT_NONE, 16'h0000, 8'h21, 3'h3, 32'h04E8_4300);
    check("esc src", {4'h0, src}, 16'h0128);
    $display("test add done");
  endtask : t_add

  task automatic t_wide();
    run(FMT_ER_ER, 16'h0000, 8'h00, 3'h4, 32'h18FF_F000);
    check("ext src", {4'h0, src}, 16'h0FFF);
    check("ext dst", {4'h0, dst}, 16'h0000);
    run(FMT_DA, 16'h0000, 8'h00, 3'h3, 32'hD6FF_FF00);
    check("direct", dir, 16'hFFFF);
    run(FMT_R_IM, 16'h0000, 8'h00, 3'h3, 32'h0C12_FF00);
    check("imm", {8'h0, imm}, 16'h00FF);
    run(FMT_ER_IM, 16'h0000, 8'h00, 3'h4, 32'h1D5A_ABC0);
    check("ext imm", {8'h0, imm}, 16'h005A);
    check("ext imm dst", {4'h0, dst}, 16'h0ABC);
    run(FMT_VEC, 16'h0000, 8'h00, 3'h2, 32'hF2FF_0000);
    check("vector", {8'h0, vec}, 16'h00FF);
    $display("test wide done");
  endtask : t_wide

  task automatic t_bit();
    run(FMT_BIT, 16'h0000, 8'h00, 3'h2, 32'hE2F3_0000);
    check("bit idx", {13'h0, bidx}, 16'h0007);
    check("pol", {15'h0, pol}, 16'h0001);
    run(FMT_BIT, 16'h0000, 8'h00, 3'h2, 32'hE205_0000);
    check("bit idx", {13'h0, bidx}, 16'h0000);
    check("pol", {15'h0, pol}, 16'h0000);
    $display("test bit done");
  endtask : t_bit

  // Even pairs pass, odd pairs raise the error flag, for both pair kinds.
  task automatic t_pair();
    run(FMT_RR, 16'h0000, 8'h00, 3'h2, 32'hA0FE_0000);
    check("pair even", {15'h0, err}, 16'h0000);
    run(FMT_RR, 16'h0000, 8'h00, 3'h2, 32'hA011_0000);
    check("pair odd", {15'h0, err}, 16'h0001);
    run(FMT_WPAIR, 16'h0000, 8'h00, 3'h2, 32'hA324_0000);
    check("wpair even", {15'h0, err}, 16'h0000);
    run(FMT_WPAIR, 16'h0000, 8'h00, 3'h2, 32'hA325_0000);
    check("wpair odd", {15'h0, err}, 16'h0001);
    $display("test pair done");
  endtask : t_pair

  // Flags are carry only, so codes 8 and 7 branch while 0, 1 and F do not.
  task automatic t_jump();
    logic [3:0] cc[5] = '{4'h8, 4'h0, 4'h7, 4'hF, 4'h1};
    logic       ex[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 5; i++) begin
      run(FMT_JRCC, 16'h0010, 8'h00, 3'h2, {cc[i], 4'hB, 8'h80, 16'h0000});
      check("cc", {12'h0, ccf}, {12'h0, cc[i]});
      check("taken", {15'h0, taken}, {15'h0, ex[i]});
      check("back target", tgt, 16'hFF92);
    end
    run(FMT_JRCC, 16'hFFF0, 8'h00, 3'h2, 32'h0B7F_0000);
    check("fwd target", tgt, 16'h0071);
    run(FMT_JRCC, 16'h0100, 8'h00, 3'h2, 32'h8BFF_0000);
    check("wrap target", tgt, 16'h0101);
    run(FMT_JPCC, 16'h0000, 8'h00, 3'h3, 32'h7D12_3400);
    check("jp target", tgt, 16'h1234);
    check("jp direct", dir, 16'h1234);
    check("jp taken", {15'h0, taken}, 16'h0001);
    $display("test jump done");
  endtask : t_jump

  // One-byte instructions: a plain one decodes clean, an unknown layout is flagged.
  task automatic t_short();
    run(FMT_NONE, 16'h0000, 8'h00, 3'h1, 32'h0F00_0000);
    check("opcode", {8'h0, opc}, 16'h000F);
    check("none err", {15'h0, err}, 16'h0000);
    run(format_t'(4'hD), 16'h0000, 8'h00, 3'h1, 32'hFF00_0000);
    check("bad fmt err", {15'h0, err}, 16'h0001);
    $display("test short done");
  endtask : t_short

  // A reset in mid-run clears the outputs; ready returns one edge after release.
  task automatic t_reset();
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    check("rst ready", {15'h0, ready}, 16'h0000);
    check("rst src", {4'h0, src}, 16'h0000);
    check("rst target", tgt, 16'h0000);
    rst_n = 1'b1;
    @(negedge clk);
    check("ready", {15'h0, ready}, 16'h0001);
    $display("test reset done");
  endtask : t_reset

  task automatic t_index();
    run(FMT_X, 16'h0000, 8'h21, 3'h3, 32'hC735_FF00);
    check("index", {4'h0, idx_a}, 16'h0124);
    $display("test index done");
  endtask : t_index

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Cut a hang short well past the hundred or so cycles the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // Reset for two cycles, then run every scenario in turn.
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_add();
    t_wide();
    t_bit();
    t_pair();
    t_short();
    t_jump();
    t_reset();
    t_index();
    tally_and_finish();
  end
endmodule : operand_field_decoder_test
